// ===== core/clk_delay_pkg.sv
// Package for the aperture delay and sync-reference window block.
// Assumes a single 125 MHz system clock and synchronous control inputs.
package clk_delay_pkg;
   // Delay code widths: 256 settings each
   localparam int DELAY_CODE_W    = 8;
   localparam int DELAY_SETTINGS  = 256;
   // Ramp: steps applied per 256 device clock cycles
   localparam int RAMP_PERIOD     = 256;
   localparam int RAMP_CNT_W      = 8;
   localparam logic [7:0] RAMP_STEP_SLOW = 8'h01;
   localparam logic [7:0] RAMP_STEP_FAST = 8'h04;
   // Sync reference capture positions
   localparam int SYNC_POS_COUNT  = 24;
   localparam int SYNC_SEL_W      = 4;   // Only first 16 positions selectable
   localparam int SYNC_SEL_COUNT  = 16;
   // Reset values
   localparam logic [7:0] COARSE_RESET = 8'h00;
   localparam logic [7:0] FINE_RESET   = 8'h00;
   localparam logic [3:0] SEL_RESET    = 4'h0;

   // Applied aperture delay travelling to the analog delay line
   typedef struct packed {
      logic       invert;
      logic [7:0] coarse;
      logic [7:0] fine;
   } aperture_delay_type;

   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b00,
      RAMP_RUN  = 2'b01
   } ramp_state_type;
endpackage

// ===== core/sync_window_detector.sv
// Sync reference window detector: flags candidate capture taps at risk.
// Assumes tap samples arrive already taken at delayed copies of the clock.
`timescale 1ns/10ps
module sync_window_detector
   import clk_delay_pkg::*;
#(
   parameter int POS_COUNT = SYNC_POS_COUNT
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // Tap samples of the sync reference, one set per sampleValid, compared with the last valid set
   input  wire logic [POS_COUNT-1:0] tapSample,
   input  wire logic                 sampleValid,
   // Flags: 1 means a potential setup or hold violation
   output logic      [POS_COUNT-1:0] positionFlags
);
   logic [POS_COUNT-1:0] prevSample_reg;
   logic [POS_COUNT-1:0] prevSample_next;
   logic [POS_COUNT-1:0] flags_reg;
   logic [POS_COUNT-1:0] flags_next;

   // A tap is risky when it disagrees with a neighbour or changed since last
   // sample: the edge lies near it. End taps have no outer neighbour, so they
   // read as risky from the first valid sample on.
   always_comb begin
      prevSample_next = prevSample_reg;
      flags_next      = flags_reg;
      if (sampleValid) begin
         prevSample_next = tapSample;
         for (int i = 0; i < POS_COUNT; i++) begin
            if (i == 0 || i == POS_COUNT - 1) begin
               flags_next[i] = 1'b1;  // [RULE13]
            end else begin
               flags_next[i] = (tapSample[i] != tapSample[i-1])
                             | (tapSample[i] != tapSample[i+1])
                             | (tapSample[i] != prevSample_reg[i]);  // [RULE12] [RULE13]
            end
         end
      end
   end

   // Registers only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prevSample_reg <= '0;
         flags_reg      <= '0;
      end else begin
         prevSample_reg <= prevSample_next;
         flags_reg      <= flags_next;
      end
   end

   assign positionFlags = flags_reg;
endmodule

// ===== core/sample_clock_delay.sv
// Function
// [RULE1] Inversion setting adds half a clock period by inverting the clock.
// [RULE2] Coarse and fine codes each give 256 delay settings.
// [RULE3] Inversion, coarse and fine act independently and combine.
// [RULE4] All internal clocks, output bus and sync capture shift with the delay.
// [RULE5] Delay settings may change on the fly without reinitialisation.
// [RULE6] Output data receiver must tolerate timing shifts on delay change.
// [RULE7] With ramp enabled, coarse delay steps gradually toward a new value.
// [RULE8] Ramp speed gives one or four coarse steps per 256 cycles.
// [RULE9] Each coarse write with ramp enabled starts a new ramp.
// [RULE10] Single-channel mode samples on both edges, doubling sync window.
// [RULE11] Sync capture instant is a delayed clock copy from candidate taps.
// [RULE12] Detect sync position in the cycle, one flag per candidate tap.
// [RULE13] Flag is 1 for setup/hold risk, 0 for a valid tap.
// [RULE14] Sync reference is captured at the selected candidate tap.
// [RULE15] Controller should pick the valid tap midway between violations.
// [RULE16] Auto calibration shifts sampling via the delay, not the reference.
// [RULE17] Captured sync event resets clock dividers and the strobe generator.
// [RULE18] Periodic sync reference runs at frame rate or an integer division.
// [RULE19] Select field addresses only the first 16 candidate taps.
// [RULE20] Ramp stops at target; inversion and fine apply directly.
// [RULE21] With ramp disabled, coarse code applies on the next cycle.
//
// Top of the aperture delay control and sync reference window logic.
// Assumes the analog delay line and tap samplers sit outside, fed by the
// registered delay word and returning tap samples synchronous to sys_clk.
`timescale 1ns/10ps
module sample_clock_delay
   import clk_delay_pkg::*;
#(
   parameter int POS_COUNT = SYNC_POS_COUNT,
   parameter int DIV_W     = 8
) (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   // Delay controls
   input  wire logic                     clockInvertDelay,
   input  wire logic [DELAY_CODE_W-1:0]  coarseDelayCode,
   input  wire logic                     coarseWrite,
   input  wire logic [DELAY_CODE_W-1:0]  fineDelayCode,
   input  wire logic                     delayRampEnable,
   input  wire logic                     delayRampSpeed,
   // Mode and calibration
   input  wire logic                     singleChannelMode,
   input  wire logic                     calEnable,
   input  wire logic                     calInvert,
   input  wire logic [DELAY_CODE_W-1:0]  calCoarse,
   // Sync reference window
   input  wire logic [POS_COUNT-1:0]     syncTapSample,
   input  wire logic                     syncSampleValid,
   input  wire logic [SYNC_SEL_W-1:0]    syncRefSampleSelect,
   // Divider setting for internal clock enables
   input  wire logic [DIV_W-1:0]         dividerLength,
   // Applied delay and status
   output aperture_delay_type            appliedDelay,
   output logic                          dualEdgeSample,
   output logic                          rampActive,
   output logic [POS_COUNT-1:0]          syncRefPositionFlags,
   output logic                          syncCaptured,
   output logic                          dividerEnable,
   output logic                          strobePulse
);
   // Ramp state
   ramp_state_type          rampState_reg;
   ramp_state_type          rampState_next;
   logic [DELAY_CODE_W-1:0] coarse_reg;
   logic [DELAY_CODE_W-1:0] coarse_next;
   logic [DELAY_CODE_W-1:0] target_reg;
   logic [DELAY_CODE_W-1:0] target_next;
   logic [RAMP_CNT_W-1:0]   rampCnt_reg;
   logic [RAMP_CNT_W-1:0]   rampCnt_next;
   logic                    rampBusy_reg;
   logic                    rampBusy_next;
   // Direct controls
   logic                    invert_reg;
   logic                    invert_next;
   logic [DELAY_CODE_W-1:0] fine_reg;
   logic [DELAY_CODE_W-1:0] fine_next;
   logic                    dual_reg;
   logic                    dual_next;
   // Sync capture and dividers
   logic                    prevSync_reg;
   logic                    prevSync_next;
   logic                    capt_reg;
   logic                    capt_next;
   logic [DIV_W-1:0]        divCnt_reg;
   logic [DIV_W-1:0]        divCnt_next;
   logic                    divEn_reg;
   logic                    divEn_next;
   logic                    strobe_reg;
   logic                    strobe_next;
   logic [7:0]              stepSize;
   logic [8:0]              gap;
   logic                    selTap;

   // Ramp engine on the coarse code
   always_comb begin
      rampState_next = rampState_reg;
      coarse_next    = coarse_reg;
      target_next    = target_reg;
      rampCnt_next   = rampCnt_reg;
      stepSize       = delayRampSpeed ? RAMP_STEP_FAST : RAMP_STEP_SLOW;  // [RULE8]
      gap            = '0;
      if (calEnable) begin
         // Calibration moves the sampling clock, never the reference
         coarse_next    = calCoarse;  // [RULE16]
         target_next    = calCoarse;
         rampState_next = RAMP_IDLE;
      end else if (coarseWrite && !delayRampEnable) begin
         coarse_next    = coarseDelayCode;  // [RULE21] [RULE5]
         target_next    = coarseDelayCode;
         rampState_next = RAMP_IDLE;
      end else if (coarseWrite) begin
         target_next    = coarseDelayCode;  // [RULE9] [RULE7]
         rampCnt_next   = '0;
         rampState_next = (coarseDelayCode == coarse_reg) ? RAMP_IDLE : RAMP_RUN;
      end else begin
         case (rampState_reg)
            RAMP_IDLE: begin
               rampCnt_next = '0;
            end
            RAMP_RUN: begin
               rampCnt_next = rampCnt_reg + 1'b1;  // Wraps every 256 cycles
               if (rampCnt_reg == RAMP_CNT_W'(RAMP_PERIOD - 1)) begin
                  // Move toward target without overshoot
                  if (target_reg > coarse_reg) begin
                     gap = {1'b0, target_reg} - {1'b0, coarse_reg};
                     coarse_next = (gap <= {1'b0, stepSize}) ? target_reg
                                 : coarse_reg + stepSize;  // [RULE7] [RULE8]
                  end else begin
                     gap = {1'b0, coarse_reg} - {1'b0, target_reg};
                     coarse_next = (gap <= {1'b0, stepSize}) ? target_reg
                                 : coarse_reg - stepSize;
                  end
                  if (gap <= {1'b0, stepSize}) begin
                     rampState_next = RAMP_IDLE;  // [RULE20]
                  end
               end
            end
            default: begin
               rampState_next = RAMP_IDLE;
            end
         endcase
      end
      // Status is registered so the pin comes straight from a flop
      rampBusy_next = (rampState_next == RAMP_RUN);
   end

   // Inversion and fine code take effect directly; all three combine
   always_comb begin
      invert_next = calEnable ? calInvert : clockInvertDelay;  // [RULE1] [RULE20]
      fine_next   = fineDelayCode;  // [RULE2] [RULE3] [RULE20]
      dual_next   = singleChannelMode;  // [RULE10]
   end

   // Sync capture at the selected tap, then divider and strobe restart.
   // Only taps 0..15 reachable since the select field is four bits wide.
   always_comb begin
      selTap        = syncTapSample[syncRefSampleSelect];  // [RULE11] [RULE14] [RULE19]
      prevSync_next = syncSampleValid ? selTap : prevSync_reg;
      capt_next     = syncSampleValid && selTap && !prevSync_reg;
      divCnt_next   = divCnt_reg;
      divEn_next    = 1'b0;
      strobe_next   = 1'b0;
      if (capt_reg) begin
         divCnt_next = '0;  // [RULE17]
         divEn_next  = 1'b1;
         strobe_next = 1'b1;
      end else if (divCnt_reg >= dividerLength) begin
         divCnt_next = '0;
         divEn_next  = 1'b1;
         strobe_next = 1'b1;
      end else begin
         divCnt_next = divCnt_reg + 1'b1;
      end
   end

   // State registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rampState_reg <= RAMP_IDLE;
         coarse_reg    <= COARSE_RESET;
         target_reg    <= COARSE_RESET;
         rampCnt_reg   <= '0;
         rampBusy_reg  <= 1'b0;
         invert_reg    <= 1'b0;
         fine_reg      <= FINE_RESET;
         dual_reg      <= 1'b0;
         prevSync_reg  <= 1'b0;
         capt_reg      <= 1'b0;
         divCnt_reg    <= '0;
         divEn_reg     <= 1'b0;
         strobe_reg    <= 1'b0;
      end else begin
         rampState_reg <= rampState_next;
         coarse_reg    <= coarse_next;
         target_reg    <= target_next;
         rampCnt_reg   <= rampCnt_next;
         rampBusy_reg  <= rampBusy_next;
         invert_reg    <= invert_next;
         fine_reg      <= fine_next;
         dual_reg      <= dual_next;
         prevSync_reg  <= prevSync_next;
         capt_reg      <= capt_next;
         divCnt_reg    <= divCnt_next;
         divEn_reg     <= divEn_next;
         strobe_reg    <= strobe_next;
      end
   end

   // Position detector
   sync_window_detector #(
      .POS_COUNT (POS_COUNT)
   ) u_detector (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .tapSample     (syncTapSample),
      .sampleValid   (syncSampleValid),
      .positionFlags (syncRefPositionFlags)  // [RULE12]
   );

   // One delay word drives every internal clock, so the output bus shifts
   // too; the receiver must ride through this.
   assign appliedDelay   = '{invert: invert_reg, coarse: coarse_reg, fine: fine_reg}; // [RULE4]
   assign dualEdgeSample = dual_reg;
   assign rampActive     = rampBusy_reg;
   assign syncCaptured   = capt_reg;
   assign dividerEnable  = divEn_reg;
   assign strobePulse    = strobe_reg;
endmodule

// ===== verif/sample_clock_delay_properties.sv
// Checker for the aperture delay block: timing relations seen at its ports.
// Assumes a bind to sample_clock_delay; every property runs on sys_clk.
`timescale 1ns/10ps
module sample_clock_delay_properties
   import clk_delay_pkg::*;
#(
   parameter int POS_COUNT = SYNC_POS_COUNT
) (
   // Clock, reset and controls
   input wire logic                    sys_clk,
   input wire logic                    rst_n,
   input wire logic                    clockInvertDelay,
   input wire logic [DELAY_CODE_W-1:0] coarseDelayCode,
   input wire logic                    coarseWrite,
   input wire logic [DELAY_CODE_W-1:0] fineDelayCode,
   input wire logic                    delayRampEnable,
   input wire logic                    calEnable,
   input wire logic [DELAY_CODE_W-1:0] calCoarse,
   input wire logic                    syncSampleValid,
   // Results
   input wire aperture_delay_type      appliedDelay,
   input wire logic                    rampActive,
   input wire logic [POS_COUNT-1:0]    syncRefPositionFlags,
   input wire logic                    syncCaptured,
   input wire logic                    strobePulse
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   logic [9:0] gapCnt;
   logic [7:0] targetReg;
   // Cycles since a taken write or a delay change; a write restarts the count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gapCnt    <= '0;
         targetReg <= '0;
      end else if (coarseWrite && !calEnable) begin
         gapCnt    <= '0;
         targetReg <= coarseDelayCode;
      end else begin
         gapCnt <= $changed(appliedDelay.coarse) ? 10'h001 : gapCnt + 10'h001;
      end
   end
   // Delay controls
   chk_fine_direct: assert property (
      $past(rst_n) |-> appliedDelay.fine == $past(fineDelayCode)) else $error("fine late");
   chk_coarse_jump: assert property (
      coarseWrite && !delayRampEnable && !calEnable
      |=> appliedDelay.coarse == $past(coarseDelayCode))
      else $error("coarse not applied");
   chk_ramp_start: assert property (
      coarseWrite && delayRampEnable && !calEnable && coarseDelayCode != appliedDelay.coarse
      |=> rampActive) else $error("ramp not started");
   chk_ramp_gap: assert property (
      $changed(appliedDelay.coarse) && $past(rampActive) && !$past(coarseWrite)
      && !$past(calEnable) |-> gapCnt inside {[256:257]}) else $error("ramp step spacing");
   chk_ramp_stop: assert property (
      $fell(rampActive) && !$past(calEnable) && !$past(coarseWrite)
      |-> appliedDelay.coarse == targetReg) else $error("ramp stopped off target");
   chk_cal_wins: assert property (
      calEnable |=> appliedDelay.coarse == $past(calCoarse)) else $error("cal not applied");
   // Sync window
   chk_end_flags: assert property (
      $past(syncSampleValid) && $past(rst_n) |-> syncRefPositionFlags[0]
      && syncRefPositionFlags[POS_COUNT-1]) else $error("end tap flag clear");
   chk_capture_cause: assert property (
      syncCaptured |-> $past(syncSampleValid)) else $error("capture without sample");
   chk_strobe_follow: assert property (
      syncCaptured |=> strobePulse) else $error("no strobe after capture");
   // Main scenarios
   cover property (rampActive ##1 !rampActive);
   cover property (syncCaptured ##1 strobePulse);
   cover property (calEnable && coarseWrite);
endmodule

// ===== verif/sync_ref_source.sv
// Sync reference source as seen through the delayed capture taps.
// Assumes the bench calls send at a falling edge of sys_clk.
`timescale 1ns/10ps
module sync_ref_source
   import clk_delay_pkg::*;
(
   // Clock
   input  wire logic                 sys_clk,
   // Tap samples and qualifier
   output logic [SYNC_POS_COUNT-1:0] tapSample = '0,
   output logic                      sampleValid = 1'b0
);
   // One sample with the edge at tap pos; later taps see the reference high.
   // Single pulses only; a periodic source would keep frame-rate spacing
   task automatic send(input int pos);
      @(negedge sys_clk);
      tapSample   = ~((24'h00_0001 << pos) - 24'h00_0001);
      sampleValid = 1'b1;
      @(negedge sys_clk);
      sampleValid = 1'b0;
      tapSample   = ~tapSample; // Stale taps show the inverse, never the last value
   endtask
endmodule

// ===== verif/sample_clock_delay_tb_top.sv
// Bench for the aperture delay block: codes, ramps, calibration, sync capture.
// Assumes the package, design, checker and sync reference source compile first.
`timescale 1ns/10ps
module sample_clock_delay_tb_top
   import clk_delay_pkg::*;
();
   // Stimulus and observed signals
   logic               sys_clk, rst_n, clockInvertDelay, coarseWrite, calEnable, calInvert;
   logic               delayRampEnable, delayRampSpeed, singleChannelMode, syncSampleValid;
   logic               dualEdgeSample, rampActive, syncCaptured, dividerEnable, strobePulse;
   logic [7:0]         coarseDelayCode, fineDelayCode, calCoarse, dividerLength;
   logic [3:0]         syncRefSampleSelect;
   logic [23:0]        syncTapSample, syncRefPositionFlags;
   aperture_delay_type appliedDelay;
   int                 nFail = 0, checkCount = 0;
   // Taps around a reference edge at tap 4; 15 is the last selectable one
   // Tap 6 sits in the high run past the edge; each pass flags it, since it rose after the all-low sample
   logic [3:0]         selTab [3] = '{4'h6, 4'h2, 4'hF};
   logic               capTab [3] = '{1'b1, 1'b0, 1'b1};
   sample_clock_delay DUT (
      .sys_clk              (sys_clk),
      .rst_n                (rst_n),
      .clockInvertDelay     (clockInvertDelay),
      .coarseDelayCode      (coarseDelayCode),
      .coarseWrite          (coarseWrite),
      .fineDelayCode        (fineDelayCode),
      .delayRampEnable      (delayRampEnable),
      .delayRampSpeed       (delayRampSpeed),
      .singleChannelMode    (singleChannelMode),
      .calEnable            (calEnable),
      .calInvert            (calInvert),
      .calCoarse            (calCoarse),
      .syncTapSample        (syncTapSample),
      .syncSampleValid      (syncSampleValid),
      .syncRefSampleSelect  (syncRefSampleSelect),
      .dividerLength        (dividerLength),
      .appliedDelay         (appliedDelay),
      .dualEdgeSample       (dualEdgeSample),
      .rampActive           (rampActive),
      .syncRefPositionFlags (syncRefPositionFlags),
      .syncCaptured         (syncCaptured),
      .dividerEnable        (dividerEnable),
      .strobePulse          (strobePulse)
   );
   sync_ref_source src (
      .sys_clk     (sys_clk),
      .tapSample   (syncTapSample),
      .sampleValid (syncSampleValid)
   );
   // Helpers: falling-edge waits, comparison, coarse write pulse, verdict
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checkCount++;
      if (got !== exp) begin
         nFail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic writeCoarse(input logic [7:0] code);
      coarseDelayCode = code;
      coarseWrite     = 1'b1;
      cyc(1);
      coarseWrite = 1'b0;
   endtask
   task automatic summarize();
      if (nFail == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Watchdog: the sequence needs about 810 cycles
   initial begin
      cyc(5000);
      nFail++;
      summarize();
   end
   // Main sequence; a long divider period keeps free-running strobes rare
   initial begin
      {clockInvertDelay, coarseWrite, calEnable, calInvert, delayRampEnable} = '0;
      {delayRampSpeed, singleChannelMode, rst_n} = '0;
      {coarseDelayCode, fineDelayCode, calCoarse, syncRefSampleSelect} = '0;
      dividerLength = 8'hFF;
      cyc(12);
      rst_n            = 1'b1;
      clockInvertDelay = 1'b1;
      fineDelayCode    = 8'hFF;
      writeCoarse(8'h80);
      check(appliedDelay, {1'b1, 8'h80, 8'hFF});
      delayRampEnable = 1'b1;
      // The bench reads each stepped delay word as it comes, no resync
      writeCoarse(8'h83);
      cyc(1);
      check(rampActive, 1'b1);
      cyc(254);
      check(appliedDelay.coarse, 8'h80);
      cyc(2);
      check(appliedDelay.coarse, 8'h81);
      fineDelayCode = 8'h12;
      cyc(1);
      check(appliedDelay.fine, 8'h12);
      // A rewrite turns the ramp round; a fast step clamps at the target
      delayRampSpeed = 1'b1;
      writeCoarse(8'h7E);
      cyc(255);
      check(appliedDelay.coarse, 8'h81);
      cyc(3);
      check({rampActive, appliedDelay.coarse}, {1'b0, 8'h7E});
      writeCoarse(8'h86);
      cyc(257);
      check(appliedDelay.coarse, 8'h82);
      delayRampEnable = 1'b0;
      writeCoarse(8'h05);
      check(appliedDelay.coarse, 8'h05);
      // Calibration owns invert and coarse; a manual write meanwhile is refused
      calCoarse = 8'h40;
      calEnable = 1'b1;
      cyc(1);
      writeCoarse(8'h22);
      check({appliedDelay.invert, appliedDelay.coarse}, {1'b0, 8'h40});
      calEnable         = 1'b0;
      singleChannelMode = 1'b1;
      cyc(1);
      check({appliedDelay.invert, dualEdgeSample}, 2'b11);
      // Capture needs the chosen tap to rise between two valid samples
      for (int i = 0; i < 3; i++) begin
         syncRefSampleSelect = selTab[i];
         src.send(SYNC_POS_COUNT);
         src.send(4);
         check(syncCaptured, capTab[i]);
         check({syncRefPositionFlags[23], syncRefPositionFlags[1:0]}, 3'b101);
         cyc(1);
         if (capTab[i]) check({strobePulse, dividerEnable}, 2'b11);
      end
      src.send(4);
      check(syncRefPositionFlags[12:8], 5'h00);
      summarize();
   end
endmodule
bind sample_clock_delay sample_clock_delay_properties #(
   .POS_COUNT (POS_COUNT)
) chk (
   .sys_clk              (sys_clk),
   .rst_n                (rst_n),
   .clockInvertDelay     (clockInvertDelay),
   .coarseDelayCode      (coarseDelayCode),
   .coarseWrite          (coarseWrite),
   .fineDelayCode        (fineDelayCode),
   .delayRampEnable      (delayRampEnable),
   .calEnable            (calEnable),
   .calCoarse            (calCoarse),
   .syncSampleValid      (syncSampleValid),
   .appliedDelay         (appliedDelay),
   .rampActive           (rampActive),
   .syncRefPositionFlags (syncRefPositionFlags),
   .syncCaptured         (syncCaptured),
   .strobePulse          (strobePulse)
);
